//--- logic/ccsr_regs.sv
// Functional notes
// RL1: Source field 00 loop, 01 internal ref, 10 external ref, 11 reserved.
// RL2: Bus rate is selected clock passed through the bus divider.
// RL3: Bus divider divides by two to the power of its code.
// RL4: Loop reference divided by factor from reference divider field and range.
// RL5: Range 0 gives 1..16; range 1 gives 32..512 for codes 000..100.
// RL6: Software keeps divided reference between 31.25 and 39.0625 kHz.
// RL7: Reference select 0 feeds external reference, 1 internal; resets to 1.
// RL8: Internal reference output runs only while its enable bit is set.
// RL9: Stop-keep clear turns internal reference off in stop mode.
// RL10: Stop-keep set keeps it if output enabled or internal mode.
// RL11: First control register resets to 04h.
// RL12: Status read-only, resets 10h; other registers read/write. Here ctl2_reg bits 3:0 and ctl4_reg bit 6 ignore writes.
// RL13: Trim register is not forced on reset.
// RL14: Unmapped gap address reads zero, writes ignored.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ccsr_defines.svh"

module ccsr_regs
  import ccsr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] status_in,
  input wire logic stop_mode,
  output ccsr_cfg_t clk_cfg,
  output logic internal_ref_clock_out,
  output logic internal_ref_run
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Word index from a byte address; low bits ignored
  function automatic logic [15:0] word_idx(input logic [15:0] addr);
    word_idx = {2'h0, addr[15:2]};
  endfunction : word_idx

  // Write merge honouring a writable-bit mask
  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // Map layout, in word indices
  // Four control words sit back to back
  // Status follows them, then one unused word
  // Oscillator control closes the map
  // Software addresses bytes: index times four
  // Only lane 0 of each word carries data
  // Upper lanes read zero and ignore writes
  // Trade-off: a word per byte keeps the bus aligned
  // Cost: the map spans four times its byte count
  // Limitation: no partial-lane merging beyond lane 0

  logic [7:0] ctl1_reg;
  logic [7:0] ctl2_reg;
  logic [7:0] ctl3_reg;
  logic [7:0] ctl4_reg;
  logic [7:0] stat_reg;
  logic [7:0] osc_reg;
  logic [15:0] awaddr_reg;
  logic aw_held_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic w_held_reg;

  // Write handshake overview
  // Address and data halves may arrive in any order
  // Whichever comes first is parked in a holding register
  // The write fires once both halves are present
  // Firing is blocked while a response still waits
  // Hazard: a new half taken under a pending response
  // Hence the readies stay low until bready is seen
  // Strobe lane 0 gates the register update only
  // A write with lane 0 clear still gets its response
  // Writes to status or the gap fire but change nothing

  // Write channel acceptance: address and data taken in either order
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire [15:0] wr_addr = aw_take ? s_axi_awaddr : awaddr_reg;
  wire [7:0] wr_data = w_take ? s_axi_wdata[7:0] : wdata_reg;
  wire wr_lane0 = w_take ? s_axi_wstrb[0] : wstrb0_reg;
  wire have_aw = aw_take || aw_held_reg;
  wire have_w = w_take || w_held_reg;
  wire wr_fire = have_aw && have_w && !s_axi_bvalid;
  wire [15:0] wr_idx = word_idx(wr_addr);
  wire wr_en = wr_fire && wr_lane0;

  // Per-register write selects; status and gap never take writes
  wire wr_c1 = wr_en && (wr_idx == word_idx(`CCSR_IDX_C1 << 2));
  wire wr_c2 = wr_en && (wr_idx == word_idx(`CCSR_IDX_C2 << 2));
  wire wr_c3 = wr_en && (wr_idx == word_idx(`CCSR_IDX_C3 << 2));
  wire wr_c4 = wr_en && (wr_idx == word_idx(`CCSR_IDX_C4 << 2));
  wire wr_osc = wr_en && (wr_idx == word_idx(`CCSR_IDX_OSC << 2)); // RL14

  // Address/data holding for the split write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
    end else begin
      if (aw_take) awaddr_reg <= s_axi_awaddr;
      if (w_take) begin
        wdata_reg <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      aw_held_reg <= have_aw && !wr_fire;
      w_held_reg <= have_w && !wr_fire;
    end
  end

  // Ready only while that half is not yet held and no response waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !(have_aw && !wr_fire) && !s_axi_bvalid && !wr_fire;
      s_axi_wready <= !(have_w && !wr_fire) && !s_axi_bvalid && !wr_fire;
    end
  end

  // Write response, always OKAY
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= 2'h0;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers with documented defaults
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl1_reg <= `CCSR_RST_C1; // RL11 RL7
      ctl2_reg <= `CCSR_RST_C2;
      ctl4_reg <= `CCSR_RST_C4;
      osc_reg <= `CCSR_RST_OSC;
    end else begin
      if (wr_c1) ctl1_reg <= wr_data; // RL12
      if (wr_c2) ctl2_reg <= merge(ctl2_reg, wr_data, `CCSR_C2_WMASK);
      if (wr_c4) ctl4_reg <= merge(ctl4_reg, wr_data, `CCSR_C4_WMASK);
      if (wr_osc) osc_reg <= wr_data;
    end
  end

  // Trim holds whatever it powers up with; reset leaves it alone
  always_ff @(posedge aclk) begin
    if (wr_c3) ctl3_reg <= wr_data; // RL13
  end

  // Status is a read-only snapshot of the clock fabric
  always_ff @(posedge aclk) begin
    if (!aresetn) stat_reg <= `CCSR_RST_ST; // RL12
    else stat_reg <= status_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel

  // Read handshake overview
  // One read in flight at a time
  // Address taken when arvalid meets arready
  // Data registered on the same edge, shown next cycle
  // Data stands until rready is sampled high
  // Arready returns one cycle after the data is taken
  // Trade-off: a dead cycle per read, but no skid buffer
  // Unmapped words read zero rather than an error code

  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [15:0] rd_idx = word_idx(s_axi_araddr);
  logic [7:0] rd_byte;

  // Read mux; gap and unmapped words read zero
  always_comb begin
    rd_byte = 8'h00; // RL14
    if (rd_idx == word_idx(`CCSR_IDX_C1 << 2)) rd_byte = ctl1_reg;
    if (rd_idx == word_idx(`CCSR_IDX_C2 << 2)) rd_byte = ctl2_reg;
    if (rd_idx == word_idx(`CCSR_IDX_C3 << 2)) rd_byte = ctl3_reg;
    if (rd_idx == word_idx(`CCSR_IDX_C4 << 2)) rd_byte = ctl4_reg;
    if (rd_idx == word_idx(`CCSR_IDX_ST << 2)) rd_byte = stat_reg;
    if (rd_idx == word_idx(`CCSR_IDX_OSC << 2)) rd_byte = osc_reg;
  end

  // Single outstanding read; arready drops while data waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= 2'h0;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock steering

  // Steering overview
  // Source field picks loop, internal or external clock
  // Bus divider turns its code into a one-hot factor
  // Reference divider adds five octaves in high range
  // Reference select feeds the loop from either side
  // Output enable gates the internal reference output
  // Stop-keep decides what survives stop mode
  // All controls leave through flip-flops
  // Hazard: a combinational path would glitch the clock muxes
  // Limitation: changes reach the fabric one cycle late
  // Software must still keep the divided rate in range
  // Nothing here checks that rate against the limits

  wire [1:0] src_code = ctl1_reg[`CCSR_C1_SRC_HI:`CCSR_C1_SRC_LO];
  wire [2:0] loop_reference_divider_code = ctl1_reg[`CCSR_C1_LOOP_REFERENCE_DIVIDER_HI:`CCSR_C1_LOOP_REFERENCE_DIVIDER_LO];
  wire [2:0] bus_divider_code = ctl2_reg[`CCSR_C2_BUS_DIVIDER_HI:`CCSR_C2_BUS_DIVIDER_LO];
  wire hi_range = osc_reg[`CCSR_OSC_RANGE];
  wire iroe = ctl1_reg[`CCSR_C1_IROE];
  wire stop_keep = ctl1_reg[`CCSR_C1_STOPK];
  wire ref_int = ctl1_reg[`CCSR_C1_REFSEL];
  // Codes above 100 are undefined; clamp to the largest factor
  wire [2:0] loop_reference_divider_lim = (loop_reference_divider_code > `CCSR_LOOP_REFERENCE_DIVIDER_MAXCODE) ?
                        `CCSR_LOOP_REFERENCE_DIVIDER_MAXCODE : loop_reference_divider_code;
  wire [3:0] ref_shift = {1'b0, loop_reference_divider_lim} +
                         (hi_range ? `CCSR_HIRANGE_SHIFT : 4'd0); // RL4 RL5
  // Internal reference is in use by loop-engaged or bypassed internal modes
  wire int_mode = (src_code == CCSR_SRC_IREF) ||
                  ((src_code == CCSR_SRC_LOOP) && ref_int);
  wire iref_keep = !stop_mode ||
                   (stop_keep && (iroe || int_mode)); // RL9 RL10
  ccsr_cfg_t cfg_next;

  // Decoded configuration; reserved source falls back to the loop
  always_comb begin
    cfg_next.bus_source_select = (src_code == CCSR_SRC_RSVD) ?
        CCSR_SRC_LOOP : ccsr_src_t'(src_code); // RL1
    cfg_next.bus_div_shift = 8'h01 << bus_divider_code; // RL2 RL3
    cfg_next.ref_div_shift = ref_shift;
    cfg_next.loop_reference_select = ref_int; // RL7
  end

  // Output register notes
  // Reset values match the reset register contents except the bus factor (01h, not 02h)
  // Internal reference runs by default outside stop
  // Output enable starts clear, so the output is idle
  // Bus factor at reset is set on the first enabled edge
  // Reference shift starts at zero, divide by one
  // Loop fed from the internal reference at reset

  // Registered so the clock fabric sees glitch-free controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_cfg <= '{CCSR_SRC_LOOP, 8'h01, 4'h0, 1'b1};
      internal_ref_clock_out <= 1'b0;
      internal_ref_run <= 1'b1;
    end else begin
      clk_cfg <= cfg_next;
      internal_ref_clock_out <= iroe && iref_keep; // RL8
      internal_ref_run <= iref_keep;
    end
  end

endmodule : ccsr_regs
`default_nettype wire

//--- logic/ccsr_defines.svh
`ifndef CCSR_DEFINES_SVH
`define CCSR_DEFINES_SVH
// Register indices, one 8-bit register per 32-bit word; byte address is 4x
`define CCSR_IDX_C1 16'h3038
`define CCSR_IDX_C2 16'h3039
`define CCSR_IDX_C3 16'h303a
`define CCSR_IDX_C4 16'h303b
`define CCSR_IDX_ST 16'h303c
`define CCSR_IDX_GAP 16'h303d
`define CCSR_IDX_OSC 16'h303e
// Reset values
`define CCSR_RST_C1 8'h04
`define CCSR_RST_C2 8'h20
`define CCSR_RST_C4 8'h00
`define CCSR_RST_ST 8'h10
`define CCSR_RST_OSC 8'h00
// Field positions
`define CCSR_C1_SRC_HI 7
`define CCSR_C1_SRC_LO 6
`define CCSR_C1_LOOP_REFERENCE_DIVIDER_HI 5
`define CCSR_C1_LOOP_REFERENCE_DIVIDER_LO 3
`define CCSR_C1_REFSEL 2
`define CCSR_C1_IROE 1
`define CCSR_C1_STOPK 0
`define CCSR_C2_BUS_DIVIDER_HI 7
`define CCSR_C2_BUS_DIVIDER_LO 5
`define CCSR_C2_WMASK 8'hf0
`define CCSR_C4_WMASK 8'hbf
`define CCSR_OSC_RANGE 4
// Extra shift applied to the reference divider in high range
`define CCSR_HIRANGE_SHIFT 4'd5
`define CCSR_LOOP_REFERENCE_DIVIDER_MAXCODE 3'd4
`endif

//--- logic/ccsr_pkg.sv
package ccsr_pkg;
  // Bus clock sources
  typedef enum logic [1:0] {
    CCSR_SRC_LOOP = 2'h0,
    CCSR_SRC_IREF = 2'h1,
    CCSR_SRC_EREF = 2'h2,
    CCSR_SRC_RSVD = 2'h3
  } ccsr_src_t;
  // Decoded clocking setup handed to the clock fabric
  typedef struct packed {
    ccsr_src_t bus_source_select;
    logic [7:0] bus_div_shift;
    logic [3:0] ref_div_shift;
    logic loop_reference_select;
  } ccsr_cfg_t;
endpackage : ccsr_pkg

//--- dv/ccsr_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ccsr_regs_monitor
  import ccsr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire ccsr_cfg_t clk_cfg
);
  // One clock domain, reset gates every check
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Request steps; write halves arrive together from the bench
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Bus answers come one cycle on and stand until accepted
  a_write_answer: assert property (s_wr_taken |=> s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_rdata_upper: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h0) else $error("upper rdata set");
  // Reserved source must never reach the clock fabric
  a_src_legal: assert property (clk_cfg.bus_source_select
    != CCSR_SRC_RSVD) else $error("reserved source");
  a_bus_divider_onehot: assert property ($onehot(clk_cfg.bus_div_shift))
    else $error("bus divider not one-hot");
  a_loop_reference_divider_span: assert property (clk_cfg.ref_div_shift <= 4'd9)
    else $error("reference divider beyond 512");
endmodule : ccsr_regs_monitor
//////////////////////////////////////////
bind ccsr_regs ccsr_regs_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .clk_cfg);
`default_nettype wire

//--- dv/clock_source_select_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccsr_defines.svh"
module clock_source_select_regs_tb;
  import ccsr_pkg::*;
  logic aclk = 0, aresetn = 0, stop_mode = 0;
  logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic internal_ref_clock_out, internal_ref_run;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] status_in = 8'h10, rv;
  logic [7:0] v [6];
  logic [15:0] ad [6] = '{`CCSR_IDX_C1, `CCSR_IDX_C2, `CCSR_IDX_C3,
    `CCSR_IDX_C4, `CCSR_IDX_ST, `CCSR_IDX_OSC};
  logic [7:0] mk [6] = '{8'hff, 8'hf0, 8'hff, 8'hbf, 8'h00, 8'hff};
  logic [7:0] rs [6] = '{8'h04, 8'h20, 8'h00, 8'h00, 8'h10, 8'h00};
  ccsr_cfg_t clk_cfg;
  int mismatches = 0, total_checks = 0, seed = 45;
  always #12.5 aclk = ~aclk;
  ccsr_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .status_in, .stop_mode,
    .clk_cfg, .internal_ref_clock_out, .internal_ref_run);
  //////////////////////////////////////////
  // Expected setup; source 11 falls back to the loop output
  function automatic ccsr_cfg_t ecfg(logic [7:0] c1, c2, o);
    ccsr_cfg_t e;
    e.bus_source_select = ccsr_src_t'(c1[7:6] == 2'h3 ? 2'h0 : c1[7:6]);
    e.bus_div_shift = 8'h01 << c2[7:5];
    e.ref_div_shift = (c1[5] ? 4'd4 : {1'b0, c1[5:3]}) + (o[4] ? 4'd5 : 4'd0);
    e.loop_reference_select = c1[2];
    return e;
  endfunction : ecfg
  // Internal mode: source 01, or loop output fed by internal reference
  function automatic logic erun(logic [7:0] c1, logic s);
    return !s || (c1[0] && (c1[1] || c1[7:6] == 2'h1 ||
      (c1[7:6] == 2'h0 && c1[2])));
  endfunction : erun
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Ready for the answer from the start; it stays high between calls
  task automatic wr(logic [15:0] ix, logic [7:0] d);
    s_axi_awaddr <= {ix[13:0], 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", 32'h0, {30'h0, s_axi_bresp});
  endtask : wr
  task automatic rd(logic [15:0] ix, output logic [7:0] d);
    s_axi_araddr <= {ix[13:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata[7:0];
    chk("rresp", 32'h0, {30'h0, s_axi_rresp});
  endtask : rd
  // Outputs lag the register by a cycle; look mid-cycle
  task automatic settle;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask : settle
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // Hang guard, far beyond the roughly 1150 cycles needed
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    summarize();
  end
  // Reset defaults, then random setups with corner codes first
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    settle;
    chk("cfg", {17'h0, ecfg(8'h04, 8'h20, 8'h00)}, {17'h0, clk_cfg});
    chk("clkout", 32'h0, {31'h0, internal_ref_clock_out});
    @(posedge aclk);
    // Trim register has no reset value, so it is skipped here
    foreach (rs[j]) if (j != 2) begin
      rd(ad[j], rv);
      chk("reset", {24'h0, rs[j]}, {24'h0, rv});
    end
    wr(`CCSR_IDX_GAP, 8'hff);
    rd(`CCSR_IDX_GAP, rv);
    chk("gap", 32'h0, {24'h0, rv});
    $display("test reset done");
    for (int i = 0; i < 30; i++) begin
      foreach (v[j]) v[j] = $random(seed);
      if (i == 0) begin
        v[0] = 8'hff;
        v[1] = 8'hff;
      end
      status_in <= $random(seed);
      foreach (v[j]) wr(ad[j], v[j]);
      stop_mode <= v[0][7:6] != 2'h3 && v[4][0];
      settle;
      chk("cfg", {17'h0, ecfg(v[0], v[1], v[5])}, {17'h0, clk_cfg});
      chk("clkout", {31'h0, v[0][1] && erun(v[0], stop_mode)}, {31'h0, internal_ref_clock_out});
      chk("run", {31'h0, erun(v[0], stop_mode)}, {31'h0, internal_ref_run});
      @(posedge aclk);
      foreach (v[j]) begin
        rd(ad[j], rv);
        chk("reg", {24'h0, j == 4 ? status_in : v[j] & mk[j]}, {24'h0, rv});
      end
    end
    $display("test random done");
    summarize();
  end
endmodule : clock_source_select_regs_tb
`default_nettype wire
